// [smc_pkg.sv]
package smc_pkg;

   // register map (byte addresses on the word-wide bus)
   localparam logic [15:0] SMC_ADDR_SETTLE = 16'hFFFA;
   localparam logic [15:0] SMC_ADDR_STATUS = 16'hFFF8;
   localparam logic [15:0] SMC_ADDR_CMD    = 16'hFFF4;

   // settle select layout and reset value
   localparam int          SMC_SETTLE_W     = 3;
   localparam logic [2:0]  SMC_SETTLE_RESET = 3'h4;

   // settle codes
   localparam logic [2:0]  SMC_CODE_P12 = 3'h0;
   localparam logic [2:0]  SMC_CODE_P14 = 3'h1;
   localparam logic [2:0]  SMC_CODE_P15 = 3'h2;
   localparam logic [2:0]  SMC_CODE_P16 = 3'h7;
   localparam logic [2:0]  SMC_CODE_P17 = 3'h4;

   // settle lengths as powers of two of main-clock periods
   localparam int          SMC_EXP_P12   = 12;
   localparam int          SMC_EXP_P14   = 14;
   localparam int          SMC_EXP_P15   = 15;
   localparam int          SMC_EXP_P16   = 16;
   localparam int          SMC_EXP_P17   = 17;
   localparam int          SMC_EXP_RESET = 17;

   localparam int          SMC_CNT_W = 18;

   // status word bit positions
   localparam int          SMC_ST_HALT   = 0;
   localparam int          SMC_ST_STOP   = 1;
   localparam int          SMC_ST_SETTLE = 2;
   localparam int          SMC_ST_BADSEL = 3;
   localparam int          SMC_ST_RSTREL = 4;

   // command word bit positions
   localparam int          SMC_CMD_HALT = 0;
   localparam int          SMC_CMD_STOP = 1;

   typedef enum logic [2:0] {
      SMC_RUN,
      SMC_HALT,
      SMC_STOP,
      SMC_OSC_START,
      SMC_SETTLE
   } smc_state_t;

endpackage

// [smc_settle_cnt.sv]
`timescale 1ns/1ps
`default_nettype none
module smc_settle_cnt
   import smc_pkg::*;
#(
   parameter int CNT_W = SMC_CNT_W
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   // control
   input  wire logic             clear,
   input  wire logic             run,
   input  wire logic [CNT_W-1:0] limit,
   // result
   output logic                  done
);

   logic [CNT_W-1:0] count_q;

   // count starts only from oscillator restart, the caller holds clear until then
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= '0;
      end else if (clear) begin
         count_q <= '0;
      end else if (run && !done) begin
         count_q <= count_q + CNT_W'(1);
      end
   end

   // limit is count-1 so done rises after exactly limit+1 counted cycles
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         done <= 1'b0;
      end else if (clear) begin
         done <= 1'b0;
      end else if (run && count_q == limit) begin
         done <= 1'b1;
      end
   end

endmodule
`default_nettype wire

// [smc_top.sv]
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module smc_top
   import smc_pkg::*;
#(
   parameter int CNT_W = SMC_CNT_W
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // avalon-mm slave
   input  wire logic [15:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // cpu core
   input  wire logic        halt_exec,
   input  wire logic        stop_exec,
   input  wire logic        global_irq_enable,
   // interrupt request logic
   input  wire logic        irq_request_flag,
   input  wire logic        irq_mask_flag,
   input  wire logic        nmi_request,
   input  wire logic        ext_irq_pin,
   // oscillator
   input  wire logic        osc_running,
   // reset from pin while stopped
   input  wire logic        reset_req_pin,
   // clock and peripheral controls
   output logic             cpu_clk_en,
   output logic             osc_enable,
   output logic             periph_clk_en,
   output logic             adc_can_stop,
   output logic             ext_irq_sense_en,
   output logic             resume_vector,
   output logic             resume_next,
   output logic             reset_process
);

   smc_state_t           state_q;
   logic [2:0]           settle_sel_q;
   logic                 from_reset_q;
   logic [CNT_W-1:0]     limit_q;
   logic                 cnt_clear;
   logic                 cnt_done;
   logic                 osc_s1_q, osc_s2_q;
   logic                 rst_s1_q, rst_s2_q;
   logic                 ext_s1_q, ext_s2_q;
   logic                 wake_irq;
   logic                 vec_pend_q;
   logic                 halt_cmd, stop_cmd;
   logic                 wr_hit, rd_hit;
   logic                 bus_done_q;
   logic                 cpu_run_d;

   // settle count minus one for a given exponent
   function automatic logic [CNT_W-1:0] settle_limit(input int exp_v);
      settle_limit = CNT_W'((64'd1 << exp_v) - 64'd1);
   endfunction

   // code lookup; prohibited codes fall back to the longest wait
   function automatic logic [CNT_W-1:0] code_limit(input logic [2:0] code);
      unique case (code)
         SMC_CODE_P12: code_limit = settle_limit(SMC_EXP_P12);
         SMC_CODE_P14: code_limit = settle_limit(SMC_EXP_P14);
         SMC_CODE_P15: code_limit = settle_limit(SMC_EXP_P15);
         SMC_CODE_P16: code_limit = settle_limit(SMC_EXP_P16);
         default:      code_limit = settle_limit(SMC_EXP_P17);
      endcase
   endfunction

   function automatic logic code_ok(input logic [2:0] code);
      code_ok = (code == SMC_CODE_P12) || (code == SMC_CODE_P14) ||
                (code == SMC_CODE_P15) || (code == SMC_CODE_P16) ||
                (code == SMC_CODE_P17);
   endfunction

   // pins from outside the clock domain
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_s1_q <= 1'b0;
         osc_s2_q <= 1'b0;
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
      end else begin
         osc_s1_q <= osc_running;
         osc_s2_q <= osc_s1_q;
         rst_s1_q <= reset_req_pin;
         rst_s2_q <= rst_s1_q;
         ext_s1_q <= ext_irq_pin;
         ext_s2_q <= ext_s1_q;
      end
   end

   // masked requests leave standby in force; nmi always wakes
   assign wake_irq = (irq_request_flag && !irq_mask_flag) || nmi_request
                     || ext_s2_q;

   // bus slave: one wait state, then answer
   // a write lands only on the edge where the master sees waitrequest low
   assign wr_hit = avs_write && !avs_waitrequest;
   assign rd_hit = avs_read && !bus_done_q;
   assign halt_cmd = halt_exec ||
      (wr_hit && avs_address == SMC_ADDR_CMD && avs_byteenable[0] &&
       avs_writedata[SMC_CMD_HALT]);
   assign stop_cmd = stop_exec ||
      (wr_hit && avs_address == SMC_ADDR_CMD && avs_byteenable[0] &&
       avs_writedata[SMC_CMD_STOP]);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_done_q <= 1'b0;
      end else begin
         bus_done_q <= (avs_read || avs_write) && !bus_done_q;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !((avs_read || avs_write) && !bus_done_q);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata <= '0;
      end else if (rd_hit) begin
         unique case (avs_address)
            SMC_ADDR_SETTLE: avs_readdata <= {29'h0, settle_sel_q};
            SMC_ADDR_STATUS: avs_readdata <= {27'h0, from_reset_q,
                                               !code_ok(settle_sel_q),
                                               state_q == SMC_SETTLE,
                                               state_q == SMC_STOP,
                                               state_q == SMC_HALT};
            default:         avs_readdata <= '0;
         endcase
      end
   end

   // select register: reset 04h, only low three bits stored
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         settle_sel_q <= SMC_SETTLE_RESET;
      end else if (wr_hit && avs_address == SMC_ADDR_SETTLE && avs_byteenable[0]) begin
         settle_sel_q <= avs_writedata[SMC_SETTLE_W-1:0];
      end
   end

   // standby state machine; the block never touches cpu state, it only gates clocks
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= SMC_RUN;
      end else begin
         unique case (state_q)
            SMC_RUN: begin
               if (stop_cmd) begin
                  state_q <= wake_irq ? SMC_OSC_START : SMC_STOP;
               end else if (halt_cmd && !wake_irq) begin
                  state_q <= SMC_HALT;
               end
            end
            SMC_HALT: begin
               if (wake_irq) begin
                  state_q <= SMC_RUN;
               end
            end
            SMC_STOP: begin
               if (wake_irq || rst_s2_q) begin
                  state_q <= SMC_OSC_START;
               end
            end
            SMC_OSC_START: begin
               if (osc_s2_q) begin
                  state_q <= SMC_SETTLE;
               end
            end
            SMC_SETTLE: begin
               if (cnt_done) begin
                  state_q <= SMC_RUN;
               end
            end
            default: state_q <= SMC_RUN;
         endcase
      end
   end

   // latch wake cause and the limit at release time
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         from_reset_q <= 1'b0;
         limit_q      <= '0;
      end else if (state_q == SMC_STOP && (wake_irq || rst_s2_q)) begin
         from_reset_q <= rst_s2_q;
         limit_q      <= rst_s2_q ? settle_limit(SMC_EXP_RESET)
                                  : code_limit(settle_sel_q);
      end else if (state_q == SMC_RUN && stop_cmd && wake_irq) begin
         from_reset_q <= 1'b0;
         limit_q      <= code_limit(settle_sel_q);
      end
   end

   assign cnt_clear = (state_q != SMC_SETTLE);

   smc_settle_cnt #(
      .CNT_W (CNT_W)
   ) u_cnt (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .clear   (cnt_clear),
      .run     (state_q == SMC_SETTLE),
      .limit   (limit_q),
      .done    (cnt_done)
   );

   // resume path: vector if enabled or nmi, else next instruction; a stop begun with a wake pending reuses the vec_pend_q of the previous wake
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         vec_pend_q <= 1'b0;
      end else if ((state_q == SMC_HALT || state_q == SMC_STOP) && wake_irq) begin
         vec_pend_q <= global_irq_enable || nmi_request;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         resume_vector <= 1'b0;
         resume_next   <= 1'b0;
         reset_process <= 1'b0;
      end else begin
         resume_vector <= 1'b0;
         resume_next   <= 1'b0;
         reset_process <= 1'b0;
         if (state_q == SMC_HALT && wake_irq) begin
            resume_vector <= global_irq_enable || nmi_request;
            resume_next   <= !(global_irq_enable || nmi_request);
         end else if (state_q == SMC_SETTLE && cnt_done) begin
            reset_process <= from_reset_q;
            resume_vector <= !from_reset_q && vec_pend_q;
            resume_next   <= !from_reset_q && !vec_pend_q;
         end
      end
   end

   // cpu clock, peripheral clock and converter stop follow the same next mode,
   // so on entry no control lags another by a cycle
   assign cpu_run_d = (state_q == SMC_RUN) && !stop_cmd && !(halt_cmd && !wake_irq);

   // clock gating outputs
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_clk_en       <= 1'b1;
         osc_enable       <= 1'b1;
         periph_clk_en    <= 1'b1;
         adc_can_stop     <= 1'b0;
         ext_irq_sense_en <= 1'b1;
      end else begin
         cpu_clk_en    <= cpu_run_d;
         osc_enable    <= !(state_q == SMC_STOP ||
                            (state_q == SMC_RUN && stop_cmd && !wake_irq));
         periph_clk_en <= ((state_q == SMC_RUN) && !stop_cmd) ||
                          (state_q == SMC_HALT);
         adc_can_stop  <= !cpu_run_d;
         ext_irq_sense_en <= 1'b1;
      end
   end

endmodule
`default_nettype wire

// [smc_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module smc_chk (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // cpu and wake sources
   input wire logic halt_exec,
   input wire logic stop_exec,
   input wire logic irq_request_flag,
   input wire logic irq_mask_flag,
   input wire logic nmi_request,
   input wire logic ext_irq_pin,
   input wire logic osc_running,
   // clock controls
   input wire logic cpu_clk_en,
   input wire logic osc_enable,
   input wire logic periph_clk_en,
   input wire logic adc_can_stop,
   input wire logic resume_vector
);
   localparam int MIN_SETTLE = 4096;
   logic        wake;
   logic        osc_q;
   logic        armed_q;
   logic [17:0] cnt_q;
   logic        ext_s1_q;
   logic        ext_s2_q;
   // the pin reaches the block through two flops, so the wake model sees it the same way
   assign wake = (irq_request_flag && !irq_mask_flag) || nmi_request || ext_s2_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // counts cycles from oscillator restart until the cpu clock returns
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_q    <= 1'b1;
         armed_q  <= 1'b0;
         cnt_q    <= '0;
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
      end else begin
         osc_q    <= osc_running;
         ext_s1_q <= ext_irq_pin;
         ext_s2_q <= ext_s1_q;
         if (osc_running && !osc_q && !cpu_clk_en) begin
            armed_q <= 1'b1;
            cnt_q   <= '0;
         end else if (cpu_clk_en) begin
            armed_q <= 1'b0;
         end else if (armed_q) begin
            cnt_q <= cnt_q + 18'h1;
         end
      end
   end
   halt_entry_a: assert property (cpu_clk_en && halt_exec && !wake |=>
      !cpu_clk_en && osc_enable && periph_clk_en) else $error("halt entry wrong");
   stop_entry_a: assert property (cpu_clk_en && stop_exec && !wake |=>
      !cpu_clk_en ##[0:2] !osc_enable) else $error("stop entry wrong");
   halt_osc_a: assert property (periph_clk_en && !cpu_clk_en |-> osc_enable)
      else $error("oscillator off in halt");
   adc_stop_a: assert property (!cpu_clk_en |-> adc_can_stop)
      else $error("adc and can not stopped");
   halt_wake_a: assert property (periph_clk_en && !cpu_clk_en && wake |->
      ##[1:3] cpu_clk_en) else $error("halt not left promptly");
   masked_hold_a: assert property ((periph_clk_en && !cpu_clk_en && !wake)[*4] |=>
      !cpu_clk_en) else $error("standby left without wake");
   nmi_vector_a: assert property (periph_clk_en && !cpu_clk_en && $rose(nmi_request) |->
      ##[1:4] resume_vector) else $error("nmi did not vector");
   settle_min_a: assert property ($rose(cpu_clk_en) && armed_q |->
      cnt_q >= MIN_SETTLE) else $error("settle wait too short");
   halt_c: cover property (cpu_clk_en && halt_exec);
   stop_c: cover property (cpu_clk_en && stop_exec);
   settle_c: cover property ($rose(cpu_clk_en) && armed_q);
endmodule
bind smc_top smc_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .halt_exec(halt_exec),
   .stop_exec(stop_exec), .irq_request_flag(irq_request_flag), .irq_mask_flag(irq_mask_flag),
   .nmi_request(nmi_request), .ext_irq_pin(ext_irq_pin), .osc_running(osc_running),
   .cpu_clk_en(cpu_clk_en), .osc_enable(osc_enable), .periph_clk_en(periph_clk_en),
   .adc_can_stop(adc_can_stop), .resume_vector(resume_vector));
`default_nettype wire

// [smc_osc_model.sv]
`timescale 1ns/1ps
`default_nettype none
// crystal takes a while to start, so the running flag lags the enable
module smc_osc_model #(
   parameter int START_DLY = 40
) (
   input  wire logic ref_clk,
   input  wire logic osc_enable,
   output var logic  osc_running
);
   int   cnt   = START_DLY;
   logic run_q = 1'b1;
   assign osc_running = run_q;
   always @(posedge ref_clk) begin
      if (!osc_enable) begin
         cnt   <= 0;
         run_q <= 1'b0;
      end else if (cnt < START_DLY) begin
         cnt <= cnt + 1;
      end else begin
         run_q <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// [smc_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module smc_top_bench;
   import smc_pkg::*;
   localparam int OSC_DLY = 40;
   logic        ref_clk, rst_n, avs_read, avs_write, avs_waitrequest;
   logic [15:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic        halt_exec, stop_exec, global_irq_enable, irq_request_flag, irq_mask_flag;
   logic        nmi_request, osc_running, cpu_clk_en, osc_enable, periph_clk_en;
   logic        adc_can_stop, ext_irq_sense_en, resume_vector, resume_next, reset_process;
   logic        v, nx, ext_pin, rst_pin;
   logic [3:0]  avs_byteenable;
   int          n_errors, n_checks, cyc, n;
   int          exps [2] = '{SMC_EXP_P12, SMC_EXP_P14};
   logic [2:0]  codes [2] = '{SMC_CODE_P12, SMC_CODE_P14};
   smc_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .halt_exec(halt_exec), .stop_exec(stop_exec), .global_irq_enable(global_irq_enable),
      .irq_request_flag(irq_request_flag), .irq_mask_flag(irq_mask_flag),
      .nmi_request(nmi_request), .ext_irq_pin(ext_pin), .osc_running(osc_running),
      .reset_req_pin(rst_pin), .cpu_clk_en(cpu_clk_en), .osc_enable(osc_enable),
      .periph_clk_en(periph_clk_en), .adc_can_stop(adc_can_stop),
      .ext_irq_sense_en(ext_irq_sense_en), .resume_vector(resume_vector),
      .resume_next(resume_next), .reset_process(reset_process));
   smc_osc_model #(.START_DLY(OSC_DLY)) u_osc (.ref_clk(ref_clk), .osc_enable(osc_enable),
      .osc_running(osc_running));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // request held until the edge where waitrequest is seen low
   task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
      avs_address   <= a;
      avs_writedata <= d;
      avs_read      <= !wr;
      avs_write     <= wr;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic pulse(input bit stp);
      if (stp) stop_exec <= 1'b1;
      else halt_exec <= 1'b1;
      @(posedge ref_clk);
      stop_exec <= 1'b0;
      halt_exec <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic collect();
      v  = 1'b0;
      nx = 1'b0;
      repeat (6) begin
         @(posedge ref_clk);
         v  = v | resume_vector;
         nx = nx | resume_next;
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_errors++;
         conclude();
      end
   end
   initial begin
      {rst_n, avs_read, avs_write, halt_exec, stop_exec, nmi_request} = '0;
      {global_irq_enable, irq_request_flag, irq_mask_flag, ext_pin, rst_pin} = '0;
      avs_byteenable = 4'hF;
      avs_address = '0;
      avs_writedata = '0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      bus(0, SMC_ADDR_SETTLE, 0); chk("settle_rst", q, 32'h4);
      bus(1, SMC_ADDR_SETTLE, 32'hFF); bus(0, SMC_ADDR_SETTLE, 0); chk("settle_wr", q, 32'h7);
      avs_byteenable <= 4'hE;
      bus(1, SMC_ADDR_SETTLE, 0);
      avs_byteenable <= 4'hF;
      bus(0, SMC_ADDR_SETTLE, 0); chk("lane_off", q, 32'h7);
      bus(0, 16'h0010, 0); chk("unmapped", q, 32'h0);
      for (int c = 0; c < 8; c++) begin
         bus(1, SMC_ADDR_SETTLE, c);
         bus(0, SMC_ADDR_STATUS, 0); chk("bad_code", q[SMC_ST_BADSEL], c inside {3, 5, 6});
      end
      irq_mask_flag <= 1'b1;
      irq_request_flag <= 1'b1;
      global_irq_enable <= 1'b1;
      pulse(0);
      chk("halt_cpu", cpu_clk_en, 0); chk("halt_osc", osc_enable, 1);
      chk("halt_adc", adc_can_stop, 1); chk("ext_sense", ext_irq_sense_en, 1);
      repeat (20) @(posedge ref_clk);
      chk("masked_hold", cpu_clk_en, 0);
      irq_mask_flag <= 1'b0;
      collect(); chk("halt_wake", {cpu_clk_en, v}, 2'b11);
      irq_request_flag <= 1'b0;
      // vectored exit, entry by command with next-instruction exit, nmi with interrupts disabled, then the pin
      for (int k = 0; k < 4; k++) begin
         global_irq_enable <= (k == 0);
         if (k == 1) bus(1, SMC_ADDR_CMD, 32'h1);
         else pulse(0);
         repeat (4) @(posedge ref_clk);
         chk("halt_in", cpu_clk_en, 0);
         if (k < 2) irq_request_flag <= 1'b1;
         else if (k == 2) nmi_request <= 1'b1;
         else ext_pin <= 1'b1;
         collect(); chk("resume", {cpu_clk_en, v, nx}, {1'b1, !k[0], k[0]});
         irq_request_flag <= 1'b0;
         nmi_request <= 1'b0;
         ext_pin <= 1'b0;
         @(posedge ref_clk);
      end
      for (int k = 0; k < 2; k++) begin
         global_irq_enable <= (k == 1);
         bus(1, SMC_ADDR_SETTLE, codes[k]);
         pulse(1);
         chk("stop_osc", {osc_enable, periph_clk_en, cpu_clk_en}, 3'b000);
         irq_request_flag <= 1'b1;
         n = 0;
         v = 1'b0;
         nx = 1'b0;
         while (cpu_clk_en !== 1'b1) begin
            @(posedge ref_clk);
            n++;
            v  = v | resume_vector;
            nx = nx | resume_next;
         end
         chk("settle_len", (n >= (1 << exps[k]) + OSC_DLY) &&
             (n < (1 << exps[k]) + OSC_DLY + 12), 1);
         chk("stop_resume", {v, nx}, {k == 1, k == 0});
         irq_request_flag <= 1'b0;
         bus(0, SMC_ADDR_SETTLE, 0); chk("settle_kept", q, codes[k]);
      end
      // a reset request leaves stop through the long fixed wait; a mid-run reset then cuts it
      bus(1, SMC_ADDR_SETTLE, SMC_CODE_P12);
      pulse(1);
      rst_pin <= 1'b1;
      repeat (4300) @(posedge ref_clk);
      rst_pin <= 1'b0;
      chk("rst_wait", {cpu_clk_en, reset_process}, 2'b00);
      bus(0, SMC_ADDR_STATUS, 0); chk("rst_status", q, 32'h14);
      rst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      chk("rst_out", {cpu_clk_en, osc_enable, periph_clk_en, adc_can_stop, avs_waitrequest},
          5'b11101);
      bus(0, SMC_ADDR_SETTLE, 0); chk("settle_rst2", q, 32'h4);
      conclude();
   end
endmodule
`default_nettype wire
